// File: pin_route_pkg.sv
// Purpose: constants shared by the pin routing matrix
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   register offsets are byte addresses
package pin_route_pkg;
	localparam int unsigned NUM_INPUTS = 8;
	localparam int unsigned NUM_PINS   = 24;
	localparam int unsigned NUM_SRCS   = 64;
	localparam int unsigned SEL_W      = 6;
	localparam logic [11:0] LOCK_OFFSET      = 12'h000;
	localparam logic [11:0] STATUS_OFFSET    = 12'h004;
	localparam logic [11:0] IN_SEL_BASE      = 12'h100;
	localparam logic [11:0] OUT_SEL_BASE     = 12'h200;
	localparam logic [7:0]  UNLOCK_KEY1      = 8'h55;
	localparam logic [7:0]  UNLOCK_KEY2      = 8'haa;
	localparam int unsigned LOCK_BIT_POS     = 0;
	localparam logic [5:0]  OUT_SEL_RESET    = 6'h00;
	localparam logic [5:0]  PORT_CODE_A      = 6'h00;
	localparam logic [5:0]  PORT_CODE_B      = 6'h01;
	localparam logic [5:0]  PORT_CODE_C      = 6'h02;
	localparam logic [5:0]  PORT_CODE_E      = 6'h04;
	// default input selections: ext interrupt, timer0 clk, timer1 clk, then more
	localparam logic [5:0] IN_SEL_RESET [NUM_INPUTS] = '{
		6'h08, 6'h04, 6'h10, 6'h0d, 6'h10, 6'h10, 6'h12, 6'h0c};
	// output codes that name a present source; others drive zero
	localparam logic [63:0] OUT_CODE_PRESENT = 64'h0001_cffe_eee1_ffff;
endpackage

// File: key_sequencer.sv
// Purpose: two-key unlock sequencer and lock bit with one-way option
// Assumes: wr_in pulses once per completed write to the lock register
// Notes:   lock bit clears on every reset
`timescale 1ns/100ps
module key_sequencer
	import pin_route_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       one_way_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	output logic            locked_out,
	output logic            relock_spent_out
);
	typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} key_state_e;
	key_state_e state_reg, state_next;
	logic       unlocked_once_reg;
	logic       new_lock;
	wire        want_lock   = wdata_in[LOCK_BIT_POS];
	// one-way: after one clear and one set, clears refused
	wire        clear_block = one_way_in && (unlocked_once_reg || relock_spent_out);
	wire        take_change = wr_in && (state_reg == KEY_ARMED);

	always_comb begin
		state_next = state_reg;
		if (wr_in) begin
			case (state_reg)
				KEY_IDLE: begin
					state_next = (wdata_in == UNLOCK_KEY1) ? KEY_GOT1 : KEY_IDLE;
				end
				KEY_GOT1: begin
					// any other write discards the partial sequence
					state_next = (wdata_in == UNLOCK_KEY2) ? KEY_ARMED : KEY_IDLE;
				end
				KEY_ARMED: state_next = KEY_IDLE;
				default:   state_next = KEY_IDLE;
			endcase
		end
	end

	always_comb begin
		new_lock = locked_out;
		if (take_change && want_lock) begin
			new_lock = 1'b1;
		end else if (take_change && !want_lock && !(clear_block && locked_out)) begin
			new_lock = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg         <= KEY_IDLE;
			locked_out        <= 1'b0;
			unlocked_once_reg <= 1'b0;
			relock_spent_out  <= 1'b0;
		end else begin
			state_reg  <= state_next;
			locked_out <= new_lock;
			if (take_change && !want_lock && locked_out && !clear_block)
				unlocked_once_reg <= 1'b1;
			if (take_change && want_lock && unlocked_once_reg && one_way_in)
				relock_spent_out <= 1'b1;
		end
	end

	chk_key_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$changed(locked_out) |-> $past(state_reg) == KEY_ARMED && $past(wr_in))
		else $error("lock bit changed without two keys");
	chk_key_abort: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		state_reg == KEY_GOT1 && wr_in && wdata_in != UNLOCK_KEY2 |=> state_reg == KEY_IDLE)
		else $error("partial key sequence not discarded");
	chk_oneway_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		one_way_in && relock_spent_out && locked_out |=> locked_out)
		else $error("one-way lock was cleared");
	cov_unlock: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		$fell(locked_out));
	cov_relock: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(relock_spent_out));
endmodule

// File: route_select.sv
// Purpose: input-side selector from port bits to one peripheral
// Assumes: pin levels already synchronised
// Notes:   reserved and absent port codes yield zero
`timescale 1ns/100ps
module route_select
	import pin_route_pkg::*;
(
	input  wire logic [5:0]  sel_in,
	input  wire logic [7:0]  port_a_in,
	input  wire logic [7:0]  port_b_in,
	input  wire logic [7:0]  port_c_in,
	input  wire logic [7:0]  port_e_in,
	output logic             level_out
);
	wire [2:0] bit_num  = sel_in[2:0];
	wire [5:0] port_sel = {3'b000, sel_in[5:3]};
	wire [7:0] port_byte =
		(port_sel == PORT_CODE_A) ? port_a_in :
		(port_sel == PORT_CODE_B) ? port_b_in :
		(port_sel == PORT_CODE_C) ? port_c_in :
		(port_sel == PORT_CODE_E) ? port_e_in : 8'h00;
	assign level_out = port_byte[bit_num];
endmodule

// File: pin_route_select_lock.sv
// Purpose: pin routing matrix with apb registers and key-protected lock
// Assumes: pins come from outside the clock domain; peripheral outputs do not
// Notes:   rst_n_in is power-on reset; soft_reset_n_in is any other reset
//
// Functional notes
// - two keys 0x55, 0xaa precede lock change
// - locked: selection writes ignored
// - unlocked: selections writable; lock resets zero
// - one-way: one clear, one set allowed
// - one-way relock sticks until reset
// - sleep leaves selections untouched
// - power-on restores defaults; other resets keep
// - bits 5:3 pick port a/b/c/e
// - bits 2:0 pick bit in port
// - output code 6 bits, upper zero
// - each input has own default code
// - absent output source drives zero
// - port reads show real pin level
`timescale 1ns/100ps
module pin_route_select_lock
	import pin_route_pkg::*;
(
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  soft_reset_n_in,
	input  wire logic                  sleep_in,
	input  wire logic                  one_time_relock_config_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [11:0]           paddr_in,
	input  wire logic [31:0]           pwdata_in,
	output logic [31:0]                prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	input  wire logic [NUM_PINS-1:0]   pin_level_in,
	input  wire logic [NUM_SRCS-1:0]   periph_out_in,
	output logic [NUM_INPUTS-1:0]      periph_in_out,
	output logic [NUM_PINS-1:0]        pin_drive_out,
	output logic [NUM_PINS-1:0]        port_read_out,
	output logic                       routing_locked_flag_out
);
	logic [5:0]          in_sel_reg  [NUM_INPUTS];
	logic [5:0]          out_sel_reg [NUM_PINS];
	logic [NUM_PINS-1:0] sync1_reg, sync2_reg, sync3_reg, pin_stable_reg;
	logic                locked;
	logic                relock_spent;
	logic                soft_rst_seen_reg;
	logic [NUM_INPUTS-1:0] in_level;

	// bus decode
	wire        access_ph  = psel_in && penable_in && !pready_out;
	wire        wr_strobe  = access_ph && pwrite_in;
	wire        rd_strobe  = access_ph && !pwrite_in;
	wire [11:0] in_rel     = paddr_in - IN_SEL_BASE;
	wire [11:0] out_rel    = paddr_in - OUT_SEL_BASE;
	wire        hit_lock   = paddr_in == LOCK_OFFSET;
	wire        hit_status = paddr_in == STATUS_OFFSET;
	wire        hit_in     = paddr_in >= IN_SEL_BASE && in_rel[1:0] == 2'b00
		&& in_rel[11:2] < 10'(NUM_INPUTS);
	wire        hit_out    = paddr_in >= OUT_SEL_BASE && out_rel[1:0] == 2'b00
		&& out_rel[11:2] < 10'(NUM_PINS);
	wire        mapped     = hit_lock || hit_status || hit_in || hit_out;
	wire [4:0]  in_idx     = in_rel[6:2];
	wire [4:0]  out_idx    = out_rel[6:2];
	// lock and sleep both freeze selections; sleep gate is belt and braces
	wire        sel_wr_ok  = !locked && !sleep_in;
	wire        lock_wr    = wr_strobe && hit_lock;
	// every reset type clears the lock and the one-way history
	wire        key_rst_n  = rst_n_in && soft_reset_n_in;

	key_sequencer u_keys (
		.clock_in         (clock_in),
		.rst_n_in         (key_rst_n),
		.one_way_in       (one_time_relock_config_in),
		.wr_in            (lock_wr),
		.wdata_in         (pwdata_in[7:0]),
		.locked_out       (locked),
		.relock_spent_out (relock_spent)
	);

	// non-power-on reset clears the lock and the one-way history; selections untouched
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in)
			soft_rst_seen_reg <= 1'b0;
		else
			soft_rst_seen_reg <= soft_rst_seen_reg || !soft_reset_n_in;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
			always_ff @(posedge clock_in or negedge rst_n_in) begin
				if (!rst_n_in)
					in_sel_reg[gi] <= IN_SEL_RESET[gi];
				else if (wr_strobe && hit_in && in_idx == 5'(gi) && sel_wr_ok)
					in_sel_reg[gi] <= pwdata_in[5:0];
			end
			route_select u_sel (
				.sel_in    (in_sel_reg[gi]),
				.port_a_in (pin_stable_reg[7:0]),
				.port_b_in (pin_stable_reg[15:8]),
				.port_c_in (pin_stable_reg[23:16]),
				.port_e_in (8'h00),
				.level_out (in_level[gi])
			);
		end
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_out
			wire [5:0] code    = out_sel_reg[gi];
			wire       present = OUT_CODE_PRESENT[code];
			always_ff @(posedge clock_in or negedge rst_n_in) begin
				if (!rst_n_in)
					out_sel_reg[gi] <= OUT_SEL_RESET;
				else if (wr_strobe && hit_out && out_idx == 5'(gi) && sel_wr_ok)
					out_sel_reg[gi] <= pwdata_in[5:0];
			end
			always_ff @(posedge clock_in or negedge rst_n_in) begin
				if (!rst_n_in)
					pin_drive_out[gi] <= 1'b0;
				else
					pin_drive_out[gi] <= present ? periph_out_in[code] : 1'b0;
			end
		end
	endgenerate

	// pin synchroniser, change accepted when stages two and three agree
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_reg      <= '0;
			sync2_reg      <= '0;
			sync3_reg      <= '0;
			pin_stable_reg <= '0;
		end else begin
			sync1_reg      <= pin_level_in;
			sync2_reg      <= sync1_reg;
			sync3_reg      <= sync2_reg;
			pin_stable_reg <= (sync2_reg & sync3_reg) | (pin_stable_reg & (sync2_reg | sync3_reg));
		end
	end

	// read mux
	wire [31:0] rd_value =
		hit_lock   ? {31'h0, locked} :
		hit_status ? {29'h0, soft_rst_seen_reg, relock_spent, locked} :
		hit_in     ? {26'h0, in_sel_reg[in_idx[2:0]]} :
		hit_out    ? {26'h0, out_sel_reg[out_idx]} : 32'h0;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out              <= 1'b0;
			pslverr_out             <= 1'b0;
			prdata_out              <= 32'h0;
			periph_in_out           <= '0;
			port_read_out           <= '0;
			routing_locked_flag_out <= 1'b0;
		end else begin
			pready_out              <= access_ph;
			pslverr_out             <= access_ph && !mapped;
			prdata_out              <= rd_strobe ? rd_value : 32'h0;
			periph_in_out           <= in_level;
			port_read_out           <= pin_stable_reg;
			routing_locked_flag_out <= locked;
		end
	end

	chk_locked_freeze: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		locked |=> $stable(out_sel_reg[0]) && $stable(in_sel_reg[0]))
		else $error("selection changed while locked");
	chk_unlocked_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		wr_strobe && hit_out && out_idx == 5'd0 && !locked && !sleep_in
		|=> out_sel_reg[0] == $past(pwdata_in[5:0]))
		else $error("unlocked write not taken");
	chk_sleep_keep: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		sleep_in |=> $stable(in_sel_reg[1]))
		else $error("selection changed in sleep");
	chk_soft_keep: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!soft_reset_n_in && !wr_strobe |=> $stable(out_sel_reg[1]))
		else $error("soft reset altered selection");
	chk_absent_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!OUT_CODE_PRESENT[out_sel_reg[2]] |=> !pin_drive_out[2])
		else $error("absent source drove pin");
	chk_upper_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		pready_out |-> prdata_out[31:6] == 26'h0 || hit_status)
		else $error("upper bits not zero");
	chk_pin_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		1'b1 |=> port_read_out == $past(pin_stable_reg))
		else $error("port read not pin level");
	chk_port_pick: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		in_sel_reg[0][5:3] == 3'b011 |=> !periph_in_out[0])
		else $error("reserved port code passed data");
	cov_sel_write: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		wr_strobe && hit_out && !locked);
	cov_locked_write: cover property (@(posedge clock_in) disable iff (!rst_n_in)
		wr_strobe && hit_in && locked);
endmodule

// File: pin_periph_model.sv
// Purpose: far side of the routing matrix: device pins and peripheral outputs
// Assumes: bench hands over the pattern to present
// Notes:   levels move just after a rising edge, like a same-clock source
`timescale 1ns/100ps
module pin_periph_model
	import pin_route_pkg::*;
(
	input  wire logic                clock_in,
	input  wire logic [31:0]         pat_in,
	output logic [NUM_PINS-1:0]      pin_level_out,
	output logic [NUM_SRCS-1:0]      periph_out_out
);
	initial begin
		pin_level_out = '0;
		periph_out_out = '0;
	end
	always @(posedge clock_in) begin
		pin_level_out  <= pat_in[NUM_PINS-1:0];
		periph_out_out <= {pat_in, ~pat_in};
	end
endmodule

// File: pin_route_select_lock_tb.sv
// Purpose: self-checking bench for the pin routing matrix
// Assumes: apb answer after one wait state; reads checked by a queue monitor
// Notes:   pins and peripheral outputs come from the far-side model
`timescale 1ns/100ps
module pin_route_select_lock_tb
	import pin_route_pkg::*;
;
	logic                  clock_in, rst_n_in, soft_reset_n_in, sleep_in, one_way;
	logic                  psel, penable, pwrite, rdy_s;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, pat, rnd;
	logic [31:0]           prdata;
	logic                  pready, pslverr, locked;
	logic [NUM_PINS-1:0]   pin_level, pin_drive, port_read;
	logic [NUM_SRCS-1:0]   periph_out, src;
	logic [NUM_INPUTS-1:0] periph_in;
	logic [32:0]           e;
	logic [32:0]           exp_q [$];
	logic [2:0]            pc [5];
	logic [2:0]            b;
	logic [5:0]            c;
	logic                  eb;
	int                    fail_count, check_count, cyc, p;

	pin_periph_model u_model (.clock_in(clock_in), .pat_in(pat), .pin_level_out(pin_level),
		.periph_out_out(periph_out));
	pin_route_select_lock u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.soft_reset_n_in(soft_reset_n_in), .sleep_in(sleep_in),
		.one_time_relock_config_in(one_way), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pin_level_in(pin_level),
		.periph_out_in(periph_out), .periph_in_out(periph_in), .pin_drive_out(pin_drive),
		.port_read_out(port_read), .routing_locked_flag_out(locked));

	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [11:0] ia(input int i);
		return IN_SEL_BASE + 12'(4 * i);
	endfunction
	function automatic logic [11:0] oa(input int i);
		return OUT_SEL_BASE + 12'(4 * i);
	endfunction

	task automatic complete_run();
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask
	// entered just after a rising edge; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do @(posedge clock_in); while (rdy_s !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
		exp_q.push_back({err, d});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic lk(input logic [31:0] v);
		apb(1'b1, LOCK_OFFSET, 32'h55);
		apb(1'b1, LOCK_OFFSET, 32'haa);
		apb(1'b1, LOCK_OFFSET, v);
	endtask
	task automatic settle();
		repeat (8) @(posedge clock_in);
	endtask
	task automatic defaults();
		for (int i = 0; i < NUM_INPUTS; i++) begin
			rd(ia(i), {26'h0, IN_SEL_RESET[i]}, 1'b0);
		end
		rd(LOCK_OFFSET, 32'h0, 1'b0);
	endtask

	// read monitor: oldest note against the answer in its pready cycle
	always @(negedge clock_in) begin
		rdy_s = pready;
		if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk(prdata, e[31:0]);
			chk({31'h0, pslverr}, {31'h0, e[32]});
		end
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			complete_run();
		end
	end

	initial begin
		rnd = 32'h35f6;
		pc = '{3'd0, 3'd1, 3'd2, 3'd4, 3'd3};
		{psel, penable, pwrite, sleep_in, one_way} = '0;
		paddr = '0;
		pwdata = '0;
		pat = '0;
		p = 0;
		rst_n_in = 1'b0;
		soft_reset_n_in = 1'b1;
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		defaults();
		rd(12'h0f0, 32'h0, 1'b1);
		for (int k = 0; k < 5; k++) begin
			rnd = xs(rnd);
			b = rnd[2:0];
			apb(1'b1, ia(0), {26'h0, pc[k], b});
			apb(1'b1, ia(3), {26'h0, pc[k], b});
			pat <= xs(rnd);
			settle();
			eb = (pc[k] < 3'd3) ? pat[{pc[k][1:0], b}] : 1'b0;
			chk({31'h0, periph_in[0]}, {31'h0, eb});
			chk({31'h0, periph_in[3]}, {31'h0, eb});
			chk({8'h0, port_read}, {8'h0, pat[23:0]});
		end
		for (int k = 0; k < 8; k++) begin
			rnd = xs(rnd);
			p = int'(rnd[12:8]) % NUM_PINS;
			c = (k == 0) ? 6'h11 : rnd[5:0];
			apb(1'b1, oa(p), {26'h3ffffff, c});
			rd(oa(p), {26'h0, c}, 1'b0);
			pat <= xs(rnd);
			settle();
			src = {pat, ~pat};
			eb = OUT_CODE_PRESENT[c] ? src[c] : 1'b0;
			chk({31'h0, pin_drive[p]}, {31'h0, eb});
		end
		lk(32'h1);
		chk({31'h0, locked}, 32'h1);
		apb(1'b1, ia(2), 32'h3f);
		rd(ia(2), {26'h0, IN_SEL_RESET[2]}, 1'b0);
		apb(1'b1, LOCK_OFFSET, 32'h55);
		apb(1'b1, LOCK_OFFSET, 32'h12);
		apb(1'b1, LOCK_OFFSET, 32'haa);
		apb(1'b1, LOCK_OFFSET, 32'h0);
		rd(LOCK_OFFSET, 32'h1, 1'b0);
		lk(32'h0);
		rd(LOCK_OFFSET, 32'h0, 1'b0);
		sleep_in <= 1'b1;
		apb(1'b1, ia(2), 32'h2a);
		sleep_in <= 1'b0;
		rd(ia(2), {26'h0, IN_SEL_RESET[2]}, 1'b0);
		apb(1'b1, ia(2), 32'h13);
		soft_reset_n_in <= 1'b0;
		settle();
		soft_reset_n_in <= 1'b1;
		@(posedge clock_in);
		rd(ia(2), 32'h13, 1'b0);
		rd(STATUS_OFFSET, 32'h4, 1'b0);
		rst_n_in <= 1'b0;
		one_way <= 1'b1;
		settle();
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		defaults();
		rd(oa(p), {26'h0, OUT_SEL_RESET}, 1'b0);
		lk(32'h1);
		lk(32'h0);
		rd(LOCK_OFFSET, 32'h0, 1'b0);
		apb(1'b1, ia(4), 32'h21);
		rd(ia(4), 32'h21, 1'b0);
		lk(32'h1);
		lk(32'h0);
		rd(LOCK_OFFSET, 32'h1, 1'b0);
		rd(STATUS_OFFSET, 32'h3, 1'b0);
		complete_run();
	end
endmodule
